// ---- logic/dcd_divider.sv ----
// Functional notes
// - two division paths from one input clock, ratios 1/2/4/8 and 2/4/8/16.
// - both paths share one counter on the same input clock edges.
// - each output runs at input frequency over its selected ratio.
// - hold only changes divider gating while the input clock is low.
// - hold control is captured on every falling input-clock edge.
// - asserted hold stops the dividers from the next falling edge on.
// - while frozen, count and outputs keep their present values; only a clear or a ratio write changes them.
// - released hold resumes after next falling edge, continuing from held count.
`include "dcd_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module dcd_divider
    import dcd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic src_clock_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic first_divided_out,
    output logic second_divided_out
);

    // selects one counter bit for a ratio; code 0 picks the undivided level in path one and counter bit 0 in path two
    // the same selector serves both paths, so a code means the same tap
    // position in each; path two is simply shifted up by one counter bit
    function automatic logic tap(input logic [1:0] pick,
                                 input logic [4:0] taps);
        tap = taps[pick];
    endfunction

    dcd_wb_req_s req;
    dcd_ctrl_s ctrl_reg;
    logic src_prev_reg;
    logic hold_reg;
    logic clear_reg;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic level_reg;
    logic first_reg;
    logic second_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;

    // bus request gathered into one carrier
    assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in,
                   sel: wb_sel_in, adr: wb_adr_in, dat: wb_dat_in};

    // bus decode: a fresh request raises ack one cycle later; the write
    // itself lands while ack is shown, at the edge where the master
    // samples ack, so control never changes before the master sees it.
    // the master keeps address, direction and data steady up to that edge
    wire access = req.cyc & req.stb & ~ack_reg;
    wire landing = req.cyc & req.stb & ack_reg;
    wire hit_ctrl = req.adr == `DCD_CTRL_ADDR;
    wire hit_stat = req.adr == `DCD_STAT_ADDR;
    wire wr_ctrl_lo = landing & req.we & hit_ctrl & req.sel[0];
    wire wr_clear = landing & req.we & hit_ctrl & req.sel[1]
                    & req.dat[`DCD_CTRL_CLEAR_BIT];

    // input clock edges as one-cycle enables
    // the input clock is treated as data on the system clock; each level
    // must last at least one system cycle or an edge is lost, and two
    // cycles a level keep every counter step cleanly separated
    wire src_rise = src_clock_in & ~src_prev_reg;
    wire src_fall = ~src_clock_in & src_prev_reg;
    wire run = ~hold_reg;

    // shared counter: one edge source for both paths
    // one counter feeds both outputs, so their common edges cannot drift
    // apart; clear wins over a step that falls in the same cycle
    assign count_next = clear_reg ? `DCD_COUNT_RESET
                        : count_reg + 4'h1;
    wire count_step = clear_reg | (src_rise & run);

    // taps per ratio: path one 1/2/4/8, path two 2/4/8/16
    wire [4:0] taps = {count_reg, level_reg};
    wire first_sel = tap(ctrl_reg.ratio_pick_first, taps);
    wire second_sel = tap(ctrl_reg.ratio_pick_second,
                          {1'b0, count_reg});

    // read data mux
    // reserved bits read as zero; unmapped addresses return all zeros
    wire [31:0] stat_word = {24'h00_0000, count_reg, 1'b0,
                             second_reg, first_reg, hold_reg};
    wire [31:0] ctrl_word = {27'h000_0000, ctrl_reg};
    wire [31:0] rd_word = hit_ctrl ? ctrl_word
                          : (hit_stat ? stat_word : 32'h0000_0000);

    // input clock edge tracker
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            src_prev_reg <= 1'b0;
        else
            src_prev_reg <= src_clock_in;
    end

    // hold captured only at falling edges, i.e. with the clock low
    // taking the hold request only at a falling edge means the divider
    // gating changes while the input clock sits low, so neither freezing
    // nor releasing can cut a high phase short and leave a runt pulse.
    // a hold written while the input clock is parked waits for its fall
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            hold_reg <= 1'b0;
        else if (src_fall)
            hold_reg <= ctrl_reg.hold;
    end

    // control register and self-clearing clear request
    // the clear bit is never stored; it becomes a one-cycle pulse that
    // restarts the shared count, which lets several dividers line up
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ctrl_reg <= dcd_ctrl_s'(`DCD_CTRL_RESET);
            clear_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl_lo)
                ctrl_reg <= dcd_ctrl_s'(req.dat[4:0]);
            clear_reg <= wr_clear;
        end
    end

    // divider state frozen while held
    // while held the count keeps its value unless a clear restarts it, and the undivided level stays
    // at the low level it had when the hold was captured, so release
    // carries on from the held state with both paths still in phase
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            count_reg <= `DCD_COUNT_RESET;
            level_reg <= 1'b0;
        end
        else
        begin
            if (count_step)
                count_reg <= count_next;
            if (clear_reg)
                level_reg <= 1'b0;
            else if (run)
                level_reg <= src_clock_in;
        end
    end

    // registered outputs
    // outputs come from flip-flops so downstream receivers never see the
    // tap selector glitch when a ratio code is rewritten
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            first_reg <= 1'b0;
            second_reg <= 1'b0;
        end
        else
        begin
            first_reg <= first_sel;
            second_reg <= second_sel;
        end
    end

    // bus answer: one ack per request, one cycle after it, zero for unmapped reads
    // ack is a single-cycle pulse; a strobe still high after it would be
    // taken again, so the master must drop its request after one ack.
    // read data is registered with the ack and holds its value until the next read is taken
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= access;
            if (access & ~req.we)
                rdata_reg <= rd_word;
        end
    end

    // drive the ports straight from their flip-flops
    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdata_reg;
    assign first_divided_out = first_reg;
    assign second_divided_out = second_reg;

endmodule

`default_nettype wire

// ---- logic/dcd_pkg.sv ----
package dcd_pkg;

    // ratio selection encoding for both paths
    typedef enum logic [1:0] {
        DCD_PICK_0 = 2'b00,
        DCD_PICK_1 = 2'b01,
        DCD_PICK_2 = 2'b10,
        DCD_PICK_3 = 2'b11
    } dcd_pick_e;

    // software control fields
    typedef struct packed {
        logic hold;
        dcd_pick_e ratio_pick_second;
        dcd_pick_e ratio_pick_first;
    } dcd_ctrl_s;

    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } dcd_wb_req_s;

endpackage

// ---- logic/dcd_regs.svh ----
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH

// register byte addresses
`define DCD_CTRL_ADDR 8'h00
`define DCD_STAT_ADDR 8'h04

// control field positions
`define DCD_CTRL_PICK_FIRST_LSB 0
`define DCD_CTRL_PICK_SECOND_LSB 2
`define DCD_CTRL_HOLD_BIT 4
`define DCD_CTRL_CLEAR_BIT 8

// status field positions
`define DCD_STAT_HOLD_BIT 0
`define DCD_STAT_FIRST_BIT 1
`define DCD_STAT_SECOND_BIT 2
`define DCD_STAT_COUNT_LSB 4

// reset values
`define DCD_CTRL_RESET 32'h0000_0000
`define DCD_COUNT_RESET 4'h0

`endif

// ---- verif/dcd_divider_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcd_divider_assertions (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic src_clock_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic first_divided_out,
    input wire logic second_divided_out
);
    logic [3:0] sh_reg;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // new request, read answer, source rise two or three edges back
    wire req_w = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire rd_w = wb_ack_out && !wb_we_in;
    wire up_w = sh_reg[2:1] == 2'b01 || sh_reg[3:2] == 2'b01;
    always_ff @(posedge clk_in) sh_reg <= {sh_reg[2:0], src_clock_in};
    property p_ack; wb_ack_out == $past(req_w); endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse; wb_ack_out |=> !wb_ack_out; endproperty
    a_pulse: assert property (p_pulse) else $error("ack long");
    property p_unmap; rd_w && wb_adr_in > 8'h04 |-> !wb_dat_out; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_ctrl; rd_w && !wb_adr_in |-> !wb_dat_out[31:5]; endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl");
    property p_stat; rd_w && wb_adr_in == 8'h04 |-> !wb_dat_out[31:8];
    endproperty
    a_stat: assert property (p_stat) else $error("stat");
    property p_up1; $rose(first_divided_out) |-> up_w; endproperty
    a_up1: assert property (p_up1) else $error("first");
    property p_up2; $rose(second_divided_out) |-> up_w; endproperty
    a_up2: assert property (p_up2) else $error("second");
    property p_rst;
        !$past(rst_b_in) |-> !first_divided_out && !second_divided_out;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    c_rd: cover property (rd_w && wb_adr_in == 8'h04);
    c_up1: cover property ($rose(first_divided_out));
    c_up2: cover property ($rose(second_divided_out));
endmodule
bind dcd_divider dcd_divider_assertions chk_u (.*);
`default_nettype wire

// ---- verif/dcd_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcd_src_model (
    input wire logic clk_in,
    input wire logic run_in,
    output logic src_out
);
    logic ph_reg = 1'b0;
    logic src_reg = 1'b0;
    assign src_out = src_reg;
    // two cycles a level; a high phase ends before parking low
    always_ff @(posedge clk_in)
    begin
        ph_reg <= !ph_reg;
        src_reg <= src_reg ^ (ph_reg && (run_in || src_reg));
    end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s %h %h", n, e, s); end end
module tb;
    import dcd_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, run = 1'b0, q1, q2, src, ack;
    logic [3:0] k;
    logic [31:0] rd, ex, lf = 32'h720ABCF8, expq[$];
    dcd_wb_req_s rq = '0;
    int err_count = 0, n_checks = 0, cyc = 0, t1, t2, sr;
    dcd_divider dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .src_clock_in(src), .wb_cyc_in(rq.cyc), .wb_stb_in(rq.stb),
        .wb_we_in(rq.we), .wb_sel_in(rq.sel), .wb_adr_in(rq.adr),
        .wb_dat_in(rq.dat), .wb_dat_out(rd), .wb_ack_out(ack),
        .first_divided_out(q1), .second_divided_out(q2));
    dcd_src_model src_u (.clk_in(clk_in), .run_in(run), .src_out(src));
    initial forever #4 clk_in = !clk_in;
    // check reads against oldest note, count edges, cut hangs
    always @(posedge clk_in)
    begin
        cyc++;
        err_count += cyc == 20000;
        if (cyc == 20000) summarize();
        if (ack && !rq.we) ex = expq.pop_front();
        if (ack && !rq.we) `CHK("read", ex, rd)
        t1 += $changed(q1);
        t2 += $changed(q2);
        sr += $rose(src);
    end
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // one classic cycle; a read notes the word expected
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_in);
        rq <= '{1'b1, 1'b1, w, 4'hF, a, d};
        if (!w) expq.push_back(d);
        do @(posedge clk_in); while (!ack);
        rq <= '0;
        @(posedge clk_in);
    endtask
    // sixteen source periods, then park
    task automatic burst();
        repeat (4) @(posedge clk_in);
        t1 = 0; t2 = 0; sr = 0;
        run <= 1'b1;
        wait (sr == 16);
        run <= 1'b0;
        repeat (10) @(posedge clk_in);
    endtask
    task automatic summarize();
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // all ratio codes, then hold and release, then an unmapped read
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        lf = nx(lf);
        wb(1'b0, 8'h04, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            k = {i[1:0] + lf[1:0], i[1:0]};
            wb(1'b1, 8'h00, {23'h0, 1'b1, 4'h0, k});
            wb(1'b0, 8'h00, {28'h0, k});
            burst();
            `CHK("first", 32 >> k[1:0], t1)
            `CHK("second", 16 >> k[3:2], t2)
        end
        wb(1'b1, 8'h00, 32'h0000_0111);
        burst();
        `CHK("held", {t1[7:0], t2[7:0]}, 16'h0101)
        wb(1'b0, 8'h04, 32'h0000_0017);
        wb(1'b1, 8'h00, 32'h0000_0001);
        burst();
        `CHK("resumed", {t1[7:0], t2[7:0]}, 16'h0F0F)
        wb(1'b0, 8'h04, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
